/* File: hw/csr_pkg.sv */
/*
 * Shared constants, types and operation codes of the core special-register block.
 * Assumes one 40 MHz clock and a CPU decoder on that same clock as the partner.
 */
package csr_pkg;

	// ----------------------------------------------------------------
	// Special register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_IND0 = 8'h00;
	localparam logic [7:0] ADDR_PTR0 = 8'h01;
	localparam logic [7:0] ADDR_IND1 = 8'h02;
	localparam logic [7:0] ADDR_PTR1 = 8'h03;
	localparam logic [7:0] ADDR_BANK = 8'h04;
	localparam logic [7:0] ADDR_ACC = 8'h05;
	localparam logic [7:0] ADDR_PCL = 8'h06;
	localparam logic [7:0] ADDR_TABLE_POINTER_LOW = 8'h07;
	localparam logic [7:0] ADDR_TABLE_RESULT_HIGH = 8'h08;
	localparam logic [7:0] ADDR_TABLE_POINTER_HIGH = 8'h09;
	localparam logic [7:0] ADDR_FLAGS = 8'h0A;
	localparam logic [7:0] GP_BASE = 8'h80;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] BANK_ZERO = 2'h0;
	localparam logic [1:0] BANK_RSVD = 2'h3;
	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_PDF = 4;
	localparam int FLAG_TO = 5;
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	localparam logic [5:0] FLAGS_WR_MASK = 6'h0F;
	localparam int RAM_DEPTH = 384;
	localparam int RAM_AW = 9;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_LDI = 4'h1,
		OP_LDA = 4'h2,
		OP_STA = 4'h3,
		OP_ADD = 4'h4,
		OP_SUB = 4'h5,
		OP_AND = 4'h6,
		OP_OR = 4'h7,
		OP_XOR = 4'h8,
		OP_INC = 4'h9,
		OP_DEC = 4'hA,
		OP_RLC = 4'hB,
		OP_TABRD = 4'hC,
		OP_CLRWDT = 4'hD,
		OP_HALT = 4'hE
	} csr_op_t;

	typedef struct packed {
		logic valid;
		csr_op_t op;
		logic [7:0] addr;
		logic [7:0] imm;
	} csr_req_t;

	typedef struct packed {
		logic is_mem;
		logic is_none;
		logic [RAM_AW-1:0] idx;
	} csr_loc_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic ac;
		logic ov;
		logic z;
		logic upd_arith;
		logic upd_z;
		logic upd_c;
	} csr_alu_out_t;

endpackage : csr_pkg

/* File: hw/csr_data_ram.sv */
/*
 * Banked general purpose data memory, one write and one registered read port.
 * Assumes the owner forms the bank-qualified index.
 */
`timescale 1ns/1ps
module csr_data_ram
	import csr_pkg::*;
(
	input wire logic clk,
	input wire logic we,
	input wire logic [RAM_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [RAM_AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [RAM_DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : csr_data_ram

/* File: hw/csr_alu.sv */
/*
 * Combinational 8-bit ALU with carry, half carry, overflow and zero results.
 * Assumes the accumulator is the left operand and memory the right one.
 */
`timescale 1ns/1ps
module csr_alu
	import csr_pkg::*;
(
	input csr_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output csr_alu_out_t y
);
	logic [7:0] bb;
	logic [4:0] lo;
	logic [3:0] hi6;
	logic [1:0] top;
	logic sub;

	always_comb begin
		sub = (op == OP_SUB);
		// Subtract as add of complement: carry out means no borrow
		bb = sub ? ~b : b;
		lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
		hi6 = {1'b0, a[6:4]} + {1'b0, bb[6:4]} + {3'h0, lo[4]};
		top = {1'b0, a[7]} + {1'b0, bb[7]} + {1'b0, hi6[3]};
		y = '0;
		y.res = {top[0], hi6[2:0], lo[3:0]};
		y.c = top[1];
		y.ac = lo[4];
		y.ov = hi6[3] ^ top[1];
		unique case (op)
			OP_ADD, OP_SUB: begin
				y.upd_arith = 1'b1;
			end
			OP_AND: y.res = a & b;
			OP_OR: y.res = a | b;
			OP_XOR: y.res = a ^ b;
			OP_INC: y.res = b + 8'h01;
			OP_DEC: y.res = b - 8'h01;
			OP_RLC: begin
				y.res = {b[6:0], cin};
				y.c = b[7];
				y.upd_c = 1'b1;
			end
			default: y.res = b;
		endcase
		y.upd_z = (op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC});
		y.z = (y.res == ZERO_BYTE);
	end
endmodule : csr_alu

/* File: hw/mcu_core_special_registers.sv */
/*
 * Core special registers: indirect ports, pointers, bank select, accumulator,
 * program counter low jump, table pointers and result, and the flags register.
 * Assumes a CPU decoder on the same clock issues one operation while ready is high,
 * and program memory answers a table fetch in the cycle the fetch strobe is high.
 */
`timescale 1ns/1ps
module mcu_core_special_registers
	import csr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic wdt_timeout,
	input wire logic sleep_mode,
	input csr_req_t req,
	input wire logic [7:0] pc_low_now,
	input wire logic [15:0] tbl_data,
	output logic ready,
	output logic done,
	output logic [7:0] acc,
	output logic [7:0] cpu_flags,
	output logic [7:0] bank_select,
	output logic pc_jump,
	output logic [7:0] pc_target,
	output logic tbl_req,
	output logic [15:0] tbl_addr
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_OPERAND = 4'b0010,
		ST_TABLE = 4'b0100,
		ST_DUMMY = 4'b1000
	} csr_state_t;

	typedef struct packed {
		csr_state_t st;
		csr_op_t op;
		csr_loc_t loc;
		logic [7:0] pointer_zero;
		logic [7:0] pointer_one;
		logic [1:0] bank_field;
		logic [7:0] acc;
		logic [7:0] table_pointer_low;
		logic [7:0] table_pointer_high;
		logic [7:0] table_result_high;
		logic [5:0] flags;
		logic ready;
		logic done;
		logic pc_jump;
		logic [7:0] pc_target;
		logic tbl_req;
		logic [15:0] tbl_addr;
	} csr_regs_t;

	localparam csr_regs_t REGS_RESET = '{
		st: ST_IDLE, op: OP_NOP, loc: '0, pointer_zero: ZERO_BYTE, pointer_one: ZERO_BYTE,
		bank_field: BANK_ZERO, acc: ZERO_BYTE, table_pointer_low: ZERO_BYTE,
		table_pointer_high: ZERO_BYTE, table_result_high: ZERO_BYTE, flags: FLAGS_RESET,
		ready: 1'b1, done: 1'b0, pc_jump: 1'b0, pc_target: ZERO_BYTE, tbl_req: 1'b0,
		tbl_addr: 16'h0000};

	csr_regs_t q;
	csr_regs_t next_q;
	csr_loc_t req_loc;
	csr_loc_t wr_loc;
	csr_alu_out_t alu_y;
	logic wr_en;
	logic [7:0] wr_data;
	logic [7:0] operand;
	logic [7:0] special_rd;
	logic [7:0] ram_rdata;
	logic ram_we;
	logic [RAM_AW-1:0] ram_raddr;

	// ----------------------------------------------------------------
	// Address resolution
	// ----------------------------------------------------------------
	// Only port one honours the bank field; everything direct stays in bank 0.
	// The special area exists in bank 0 only, so low addresses in banks 1
	// and 2 behave as unused and read zero.
	function automatic csr_loc_t resolve(input logic [7:0] a, input logic [7:0] p0,
		input logic [7:0] p1, input logic [1:0] bk);
		csr_loc_t l;
		logic [7:0] ea;
		logic [1:0] eb;
		l = '0;
		ea = a;
		eb = BANK_ZERO;
		if (a == ADDR_IND0) begin
			ea = p0;
		end else if (a == ADDR_IND1) begin
			ea = p1;
			eb = bk;
		end
		if (eb == BANK_RSVD) begin
			l.is_none = 1'b1;
		end else if (ea == ADDR_IND0 || ea == ADDR_IND1) begin
			l.is_none = 1'b1;
		end else if (ea >= GP_BASE) begin
			l.is_mem = 1'b1;
			l.idx = {eb, ea[6:0]};
		end else if (eb != BANK_ZERO) begin
			l.is_none = 1'b1;
		end else begin
			l.idx = {1'b0, ea};
		end
		return l;
	endfunction : resolve

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	csr_data_ram u_ram (
		.clk(clk),
		.we(ram_we),
		.waddr(wr_loc.idx),
		.wdata(wr_data),
		.raddr(ram_raddr),
		.rdata(ram_rdata)
	);

	csr_alu u_alu (
		.op(q.op),
		.a(q.acc),
		.b(operand),
		.cin(q.flags[FLAG_C]),
		.y(alu_y)
	);

	// ----------------------------------------------------------------
	// Special register read mux
	// ----------------------------------------------------------------
	always_comb begin
		unique case (q.loc.idx[7:0])
			ADDR_PTR0: special_rd = q.pointer_zero;
			ADDR_PTR1: special_rd = q.pointer_one;
			ADDR_BANK: special_rd = {6'h00, q.bank_field};
			ADDR_ACC: special_rd = q.acc;
			ADDR_PCL: special_rd = pc_low_now;
			ADDR_TABLE_POINTER_LOW: special_rd = q.table_pointer_low;
			ADDR_TABLE_RESULT_HIGH: special_rd = q.table_result_high;
			ADDR_TABLE_POINTER_HIGH: special_rd = q.table_pointer_high;
			ADDR_FLAGS: special_rd = {2'b00, q.flags};
			default: special_rd = ZERO_BYTE;
		endcase
		if (q.loc.is_none) begin
			operand = ZERO_BYTE;
		end else if (q.loc.is_mem) begin
			operand = ram_rdata;
		end else begin
			operand = special_rd;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.pc_jump = 1'b0;
		next_q.tbl_req = 1'b0;
		req_loc = resolve(req.addr, q.pointer_zero, q.pointer_one, q.bank_field);
		wr_en = 1'b0;
		wr_loc = q.loc;
		wr_data = ZERO_BYTE;
		ram_raddr = req_loc.idx;
		unique case (q.st)
			ST_IDLE: begin
				if (req.valid) begin
					next_q.op = req.op;
					next_q.loc = req_loc;
					next_q.done = 1'b1;
					unique case (req.op)
						OP_NOP: ;
						OP_LDI: next_q.acc = req.imm;
						OP_STA: begin
							wr_en = 1'b1;
							wr_loc = req_loc;
							wr_data = q.acc;
						end
						OP_TABRD: begin
							next_q.done = 1'b0;
							next_q.tbl_req = 1'b1;
							next_q.tbl_addr = {q.table_pointer_high, q.table_pointer_low};
							next_q.st = ST_TABLE;
						end
						OP_CLRWDT: begin
							next_q.flags[FLAG_PDF] = 1'b0;
							next_q.flags[FLAG_TO] = 1'b0;
						end
						OP_HALT: begin
							next_q.flags[FLAG_PDF] = 1'b1;
							next_q.flags[FLAG_TO] = 1'b0;
						end
						default: begin
							// Memory read data is registered, so fetch first
							next_q.done = 1'b0;
							next_q.st = ST_OPERAND;
						end
					endcase
				end
			end
			ST_OPERAND: begin
				next_q.done = 1'b1;
				next_q.st = ST_IDLE;
				if (q.op == OP_INC || q.op == OP_DEC) begin
					wr_en = 1'b1;
					wr_data = alu_y.res;
				end else begin
					next_q.acc = alu_y.res;
				end
				if (alu_y.upd_arith) begin
					next_q.flags[FLAG_C] = alu_y.c;
					next_q.flags[FLAG_AC] = alu_y.ac;
					next_q.flags[FLAG_OV] = alu_y.ov;
				end
				if (alu_y.upd_c) begin
					next_q.flags[FLAG_C] = alu_y.c;
				end
				if (alu_y.upd_z) begin
					next_q.flags[FLAG_Z] = alu_y.z;
				end
			end
			ST_TABLE: begin
				next_q.table_result_high = tbl_data[15:8];
				wr_en = 1'b1;
				wr_data = tbl_data[7:0];
				next_q.done = 1'b1;
				next_q.st = ST_IDLE;
			end
			ST_DUMMY: begin
				next_q.done = 1'b1;
				next_q.st = ST_IDLE;
			end
		endcase

		// A write to a special location lands after the flag update, so
		// software writing the flags register wins over the ALU result.
		if (wr_en && !wr_loc.is_mem && !wr_loc.is_none) begin
			unique case (wr_loc.idx[7:0])
				ADDR_PTR0: next_q.pointer_zero = wr_data;
				ADDR_PTR1: next_q.pointer_one = wr_data;
				ADDR_BANK: next_q.bank_field = wr_data[1:0];
				ADDR_ACC: next_q.acc = wr_data;
				ADDR_TABLE_POINTER_LOW: next_q.table_pointer_low = wr_data;
				ADDR_TABLE_RESULT_HIGH: next_q.table_result_high = wr_data;
				ADDR_TABLE_POINTER_HIGH: next_q.table_pointer_high = wr_data;
				ADDR_PCL: begin
					next_q.pc_jump = 1'b1;
					next_q.pc_target = wr_data;
					next_q.done = 1'b0;
					next_q.st = ST_DUMMY;
				end
				ADDR_FLAGS: begin
					next_q.flags = (q.flags & ~FLAGS_WR_MASK)
						| (wr_data[5:0] & FLAGS_WR_MASK);
				end
				default: ;
			endcase
		end

		// Watchdog time-out drops the operation in flight and keeps every register,
		// so no half-done update lands; only TO and, outside sleep mode, the bank field move
		if (wdt_timeout) begin
			next_q = q;
			next_q.st = ST_IDLE;
			next_q.done = 1'b0;
			next_q.pc_jump = 1'b0;
			next_q.tbl_req = 1'b0;
			next_q.flags[FLAG_TO] = 1'b1;
			if (!sleep_mode) begin
				next_q.bank_field = BANK_ZERO;
			end
		end
		ram_we = wr_en && wr_loc.is_mem && !wdt_timeout;
		next_q.ready = (next_q.st == ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= REGS_RESET;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Flags are only exposed, never stacked: saving them is up to software.
	assign ready = q.ready;
	assign done = q.done;
	assign acc = q.acc;
	assign cpu_flags = {2'b00, q.flags};
	assign bank_select = {6'h00, q.bank_field};
	assign pc_jump = q.pc_jump;
	assign pc_target = q.pc_target;
	assign tbl_req = q.tbl_req;
	assign tbl_addr = q.tbl_addr;
endmodule : mcu_core_special_registers

/* File: verification/csr_props.sv */
/*
 * Port-level checker for the core special-register block.
 * Assumes it is bound to the block's top module and sees one clock domain.
 */
`timescale 1ns/1ps
module csr_props
	import csr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic wdt_timeout,
	input wire logic sleep_mode,
	input csr_req_t req,
	input wire logic [7:0] pc_low_now,
	input wire logic [15:0] tbl_data,
	input wire logic ready,
	input wire logic done,
	input wire logic [7:0] acc,
	input wire logic [7:0] cpu_flags,
	input wire logic [7:0] bank_select,
	input wire logic pc_jump,
	input wire logic [7:0] pc_target,
	input wire logic tbl_req,
	input wire logic [15:0] tbl_addr
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	// A watchdog event in the same cycle blocks acceptance
	logic take;
	assign take = req.valid && ready && !wdt_timeout;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_bank_upper_zero: assert property (bank_select[7:2] == 6'h00)
		else $error("bank select upper bits set");
	chk_flags_upper_zero: assert property (cpu_flags[7:6] == 2'h0)
		else $error("flags upper bits set");
	chk_ldi_acc: assert property (take && req.op == OP_LDI |=> done && acc == $past(req.imm))
		else $error("immediate load did not reach accumulator");
	chk_jump_dummy: assert property (take && req.op == OP_STA && req.addr == ADDR_PCL
		|=> pc_jump && !done && pc_target == $past(acc) ##1 done)
		else $error("jump without dummy cycle");
	chk_wdt_sets_to: assert property (wdt_timeout |=> cpu_flags[5])
		else $error("time-out flag not set");
	chk_bank_keep_sleep: assert property (wdt_timeout && sleep_mode |=> $stable(bank_select))
		else $error("bank lost on sleeping time-out");
	chk_bank_clear_wdt: assert property (wdt_timeout && !sleep_mode |=> bank_select == 8'h00)
		else $error("bank kept on waking time-out");
	chk_halt_flags: assert property (take && req.op == OP_HALT |=> cpu_flags[5:4] == 2'h1)
		else $error("halt flags wrong");
	chk_pdf_cause: assert property ($changed(cpu_flags[4]) |-> $past(reset)
		|| ($past(take) && $past(req.op) inside {OP_HALT, OP_CLRWDT}))
		else $error("power-down flag moved without cause");
	chk_flags_wr_mask: assert property (take && req.op == OP_STA && req.addr == ADDR_FLAGS
		|=> cpu_flags[5:0] == {$past(cpu_flags[5:4]), $past(acc[3:0])})
		else $error("flags write wrong");
	chk_alu_busy: assert property (take && req.op inside {OP_ADD, OP_SUB}
		|=> !ready && !done ##1 ready && (done || $past(wdt_timeout)))
		else $error("arithmetic operation timing wrong");
	chk_tbl_fetch: assert property (take && req.op == OP_TABRD
		|=> tbl_req && !done ##1 done && !tbl_req)
		else $error("table fetch sequence wrong");

	cov_jump: cover property (pc_jump);
	cov_table: cover property (tbl_req);
	cov_wdt_sleep: cover property (wdt_timeout && sleep_mode);
endmodule : csr_props

/* File: verification/csr_prog_mem.sv */
/*
 * Program memory model answering table fetches of the special-register block.
 * Assumes fetch strobe and address are registered on the same clock.
 */
`timescale 1ns/1ps
module csr_prog_mem
	import csr_pkg::*;
(
	input wire logic clk,
	input wire logic tbl_req,
	input wire logic [15:0] tbl_addr,
	output logic [15:0] tbl_data
);
	logic [15:0] junk = 16'h0000;
	// Outside a fetch the bus churns so a late sample cannot pass by luck
	always_ff @(posedge clk) begin
		junk <= junk + 16'h1357;
	end
	assign tbl_data = tbl_req ? {~tbl_addr[7:0], tbl_addr[15:8] ^ 8'h5A} : junk;
endmodule : csr_prog_mem

/* File: verification/testbench.sv */
/*
 * Self-checking bench: operation calls with expected values.
 * Assumes the package, the design files and the checker are compiled first.
 */
`timescale 1ns/1ps
module testbench
	import csr_pkg::*;
;
	logic clk, reset, wdt_timeout, sleep_mode, ready, done, pc_jump, tbl_req, jmp_seen;
	csr_req_t req;
	logic [7:0] pc_low_now, acc, cpu_flags, bank_select, pc_target;
	logic [15:0] tbl_data, tbl_addr;
	logic [11:0] e;
	int fails, n_checks, lat;
	logic [7:0] opa [5] = '{8'h7F, 8'hFF, 8'h0F, 8'h80, 8'h10};
	logic [7:0] opb [5] = '{8'h01, 8'h01, 8'h01, 8'h80, 8'h20};

	mcu_core_special_registers i_dut (.clk(clk), .reset(reset), .wdt_timeout(wdt_timeout),
		.sleep_mode(sleep_mode), .req(req), .pc_low_now(pc_low_now), .tbl_data(tbl_data),
		.ready(ready), .done(done), .acc(acc), .cpu_flags(cpu_flags),
		.bank_select(bank_select), .pc_jump(pc_jump), .pc_target(pc_target),
		.tbl_req(tbl_req), .tbl_addr(tbl_addr));
	csr_prog_mem i_pmem (.clk(clk), .tbl_req(tbl_req), .tbl_addr(tbl_addr),
		.tbl_data(tbl_data));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Issue one operation and wait, bounded, for its completion pulse
	task automatic op(input csr_op_t o, input logic [7:0] a, input logic [7:0] i);
		@(posedge clk);
		req <= '{1'b1, o, a, i};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		jmp_seen = pc_jump;
		lat = 1;
		while (done !== 1'b1 && lat < 8) begin
			@(posedge clk);
			#1;
			lat++;
		end
		chk({6'h00, ready, done}, 8'h03);
	endtask : op

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		op(OP_LDI, 8'h00, v);
		op(OP_STA, a, 8'h00);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		op(OP_LDA, a, 8'h00);
		chk(acc, exp);
	endtask : rdc

	task automatic pulse_wdt(input logic slp);
		@(posedge clk);
		wdt_timeout <= 1'b1;
		sleep_mode <= slp;
		@(posedge clk);
		wdt_timeout <= 1'b0;
		sleep_mode <= 1'b0;
		#1;
	endtask : pulse_wdt

	function automatic logic [11:0] alu_exp(input logic sub, input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] m;
		logic [8:0] s;
		logic [4:0] lo;
		logic [7:0] mid;
		m = sub ? ~b : b;
		s = {1'b0, a} + {1'b0, m} + {8'h00, sub};
		lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, sub};
		mid = {1'b0, a[6:0]} + {1'b0, m[6:0]} + {7'h00, sub};
		return {s[7:0], mid[7] ^ s[8], s[7:0] == 8'h00, lo[4], s[8]};
	endfunction : alu_exp

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Whole run is a few hundred cycles; this bound leaves ample slack
	initial begin
		#(25 * 5000);
		fails++;
		report_and_stop();
	end

	initial begin
		reset = 1'b1;
		wdt_timeout = 1'b0;
		sleep_mode = 1'b0;
		req = '0;
		pc_low_now = 8'h5A;
		fails = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(bank_select, 8'h00);
		chk(cpu_flags, 8'h00);
		wr(ADDR_BANK, 8'hFE);
		chk(bank_select, 8'h02);
		rdc(ADDR_BANK, 8'h02);
		wr(ADDR_BANK, 8'h01);
		wr(8'h90, 8'h11);
		wr(ADDR_PTR1, 8'h90);
		wr(ADDR_IND1, 8'h22);
		wr(ADDR_BANK, 8'h02);
		wr(ADDR_IND1, 8'h33);
		rdc(8'h90, 8'h11);
		wr(ADDR_BANK, 8'h03);
		wr(ADDR_IND1, 8'h44);
		rdc(ADDR_IND1, 8'h00);
		wr(ADDR_BANK, 8'h00);
		rdc(ADDR_IND1, 8'h11);
		wr(ADDR_PTR0, 8'h90);
		rdc(ADDR_IND0, 8'h11);
		wr(ADDR_BANK, 8'h01);
		rdc(ADDR_IND1, 8'h22);
		rdc(ADDR_IND0, 8'h11);
		wr(ADDR_BANK, 8'h02);
		rdc(ADDR_IND1, 8'h33);
		wr(ADDR_PTR0, ADDR_IND1);
		wr(ADDR_IND0, 8'h55);
		rdc(ADDR_IND0, 8'h00);
		rdc(ADDR_IND1, 8'h33);
		wr(ADDR_PTR0, 8'h90);
		op(OP_INC, ADDR_PTR0, 8'h00);
		rdc(ADDR_PTR0, 8'h91);
		for (int k = 0; k < 10; k++) begin
			wr(8'h81, opb[k % 5]);
			op(OP_LDI, 8'h00, opa[k % 5]);
			op(k < 5 ? OP_ADD : OP_SUB, 8'h81, 8'h00);
			e = alu_exp(k >= 5, opa[k % 5], opb[k % 5]);
			chk(acc, e[11:4]);
			chk({4'h0, cpu_flags[3:0]}, {4'h0, e[3:0]});
		end
		op(OP_LDI, 8'h00, 8'h0F);
		op(OP_AND, 8'h81, 8'h00);
		chk(acc, 8'h00);
		chk(cpu_flags & 8'h04, 8'h04);
		op(OP_OR, 8'h81, 8'h00);
		chk(acc, 8'h20);
		chk(cpu_flags & 8'h04, 8'h00);
		op(OP_XOR, 8'h81, 8'h00);
		chk(acc, 8'h00);
		chk(cpu_flags & 8'h04, 8'h04);
		op(OP_DEC, ADDR_PTR0, 8'h00);
		chk(cpu_flags & 8'h04, 8'h00);
		rdc(ADDR_PTR0, 8'h90);
		wr(8'h81, 8'hC0);
		op(OP_RLC, 8'h81, 8'h00);
		chk(acc, 8'h80);
		chk(cpu_flags & 8'h01, 8'h01);
		op(OP_RLC, 8'h81, 8'h00);
		op(OP_NOP, 8'h00, 8'h00);
		chk(acc, 8'h81);
		wr(ADDR_FLAGS, 8'hFF);
		chk(cpu_flags, 8'h0F);
		op(OP_HALT, 8'h00, 8'h00);
		chk(cpu_flags & 8'h30, 8'h10);
		wr(ADDR_FLAGS, 8'h00);
		chk(cpu_flags, 8'h10);
		pulse_wdt(1'b1);
		chk(bank_select, 8'h02);
		chk(cpu_flags, 8'h30);
		pulse_wdt(1'b0);
		chk(bank_select, 8'h00);
		op(OP_CLRWDT, 8'h00, 8'h00);
		chk(cpu_flags & 8'h30, 8'h00);
		pulse_wdt(1'b0);
		op(OP_HALT, 8'h00, 8'h00);
		chk(cpu_flags & 8'h30, 8'h10);
		wr(ADDR_PCL, 8'h3C);
		chk({7'h00, jmp_seen}, 8'h01);
		chk(lat[7:0], 8'h02);
		chk(pc_target, 8'h3C);
		wr(ADDR_TABLE_POINTER_LOW, 8'h34);
		wr(ADDR_TABLE_POINTER_HIGH, 8'h12);
		op(OP_TABRD, 8'h85, 8'h00);
		chk(tbl_addr[15:8], 8'h12);
		chk(tbl_addr[7:0], 8'h34);
		rdc(8'h85, 8'h48);
		rdc(ADDR_TABLE_RESULT_HIGH, 8'hCB);
		op(OP_INC, ADDR_TABLE_POINTER_LOW, 8'h00);
		op(OP_TABRD, 8'h86, 8'h00);
		rdc(ADDR_TABLE_RESULT_HIGH, 8'hCA);
		wr(ADDR_BANK, 8'h02);
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		#1;
		chk(bank_select, 8'h00);
		chk(cpu_flags, 8'h00);
		report_and_stop();
	end
endmodule : testbench

bind mcu_core_special_registers csr_props i_props (.clk(clk), .reset(reset),
	.wdt_timeout(wdt_timeout), .sleep_mode(sleep_mode), .req(req), .pc_low_now(pc_low_now),
	.tbl_data(tbl_data), .ready(ready), .done(done), .acc(acc), .cpu_flags(cpu_flags),
	.bank_select(bank_select), .pc_jump(pc_jump), .pc_target(pc_target),
	.tbl_req(tbl_req), .tbl_addr(tbl_addr));
